// [src/tes_edge_shaper.sv]
// Tx edge shaper: APB register file, edge style decode and carrier-cycle stepping
//
// The implementer's own choice: the APB slave port.
module tes_edge_shaper (
  input wire logic ref_clk_i,                   // 100 MHz clock
  input wire logic srst_i,                      // Synchronous reset, active high
  input wire tes_pkg::tes_apb_req_t apb_req_i,  // APB request
  output tes_pkg::tes_apb_rsp_t apb_rsp_o,      // APB answer
  input wire logic carrier_tick_i,              // One pulse per carrier cycle
  input wire logic mod_req_i,                   // High while carrier is to be modulated
  output tes_pkg::tes_tx_drive_t tx_drive_o     // Setting for the output stage
);
  import tes_pkg::*;

  function automatic tes_style_t tes_decode(input logic [3:0] code);
    tes_style_t s;
    s = '0;
    if (code >= 4'h1 && code <= 4'h3) begin
      s.valid = 1'b1;
      s.segments = code[1:0];
    end else if (code >= 4'h4 && code <= 4'h6) begin
      s.valid = 1'b1;
      s.lut = 1'b1;
      s.adapt = (code != 4'h4);
      s.correct = (code == 4'h5);
    end
    return s;
  endfunction : tes_decode

  function automatic logic [7:0] tes_ramp(input logic [7:0] lo, input logic [4:0] k,
                                          input logic [4:0] n);
    logic [12:0] prod;
    logic [12:0] quot;
    prod = 13'((TES_FULL_CARRIER - lo) * k);
    quot = '0;
    if (n == 5'h0) begin
      return TES_FULL_CARRIER;
    end
    quot = prod / 13'(n);
    return 8'(lo + quot[7:0]);
  endfunction : tes_ramp

  function automatic logic [TES_ADDR_W-1:0] tes_byte_addr(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : tes_byte_addr

  logic [7:0] res_106k_q;
  logic [7:0] kind_106k_q;
  logic [7:0] style_q;
  logic [7:0] length_q;
  logic [7:0] res_212k_q;
  logic [7:0] kind_212k_q;
  logic [1:0] ctrl_q;
  tes_state_t state_q, state_d;
  logic [4:0] step_q, step_d;
  logic hold_q, hold_d;
  tes_apb_rsp_t apb_rsp_d;
  tes_tx_drive_t drive_d;

  // Bus decode
  wire setup_phase = apb_req_i.psel && !apb_req_i.penable;
  wire wr_commit = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready &&
                   apb_req_i.pwrite && !apb_rsp_o.pslverr;
  wire [7:0] wr_byte = apb_req_i.pwdata[7:0];
  wire wr_res_106k = wr_commit && apb_req_i.paddr == tes_byte_addr(TES_IDX_RES_106K);
  wire wr_kind_106k = wr_commit && apb_req_i.paddr == tes_byte_addr(TES_IDX_KIND_106K);
  wire wr_style = wr_commit && apb_req_i.paddr == tes_byte_addr(TES_IDX_STYLE_106K);
  wire wr_length = wr_commit && apb_req_i.paddr == tes_byte_addr(TES_IDX_LENGTH_106K);
  wire wr_res_212k = wr_commit && apb_req_i.paddr == tes_byte_addr(TES_IDX_RES_212K);
  wire wr_kind_212k = wr_commit && apb_req_i.paddr == tes_byte_addr(TES_IDX_KIND_212K);
  wire wr_ctrl = wr_commit && apb_req_i.paddr == tes_byte_addr(TES_IDX_CTRL);

  // Configuration in force for the selected rate
  wire rate_212k = ctrl_q[TES_CTRL_RATE_BIT];
  wire shaper_en = ctrl_q[TES_CTRL_EN_BIT];
  wire [7:0] kind_sel = rate_212k ? kind_212k_q : kind_106k_q;
  wire [7:0] res_sel = rate_212k ? res_212k_q : res_106k_q;
  wire [3:0] fall_code = kind_sel[7:4];
  wire [3:0] rise_code = kind_sel[3:0];
  wire tes_style_t fall_style = tes_decode(fall_code);
  wire tes_style_t rise_style = tes_decode(rise_code);
  wire [2:0] fall_field = style_q[6:4];
  wire [2:0] rise_field = style_q[2:0];
  wire [4:0] n_states = length_q[4:0];
  wire double_len = length_q[TES_LEN_SCALE_BIT];

  // A state lasts until the hold count reaches the scale bit: 1 or 2 carrier cycles
  wire in_edge = (state_q == TES_ST_FALL) || (state_q == TES_ST_RISE);
  wire step_adv = in_edge && carrier_tick_i && (hold_q == double_len);
  wire last_state = (step_q >= n_states - 5'h1);
  wire fall_skip = !fall_style.valid || n_states == 5'h0;
  wire rise_skip = !rise_style.valid || n_states == 5'h0;
  wire edge_rising = (state_q == TES_ST_RISE);
  wire tes_style_t cur_style = edge_rising ? rise_style : fall_style;
  wire [2:0] cur_field = edge_rising ? rise_field : fall_field;

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    hold_d = 1'b0;
    if (in_edge && carrier_tick_i && !step_adv) begin
      hold_d = 1'b1;
    end else if (in_edge && !carrier_tick_i) begin
      hold_d = hold_q;
    end
    case (state_q)
      TES_ST_IDLE: begin
        step_d = '0;
        if (shaper_en && mod_req_i) begin
          state_d = fall_skip ? TES_ST_LOW : TES_ST_FALL;
        end
      end
      TES_ST_FALL: begin
        if (step_adv && last_state) begin
          state_d = TES_ST_LOW;
          step_d = '0;
        end else if (step_adv) begin
          step_d = step_q + 5'h1;
        end
      end
      TES_ST_LOW: begin
        step_d = '0;
        if (!mod_req_i) begin
          state_d = rise_skip ? TES_ST_IDLE : TES_ST_RISE;
        end
      end
      TES_ST_RISE: begin
        if (step_adv && last_state) begin
          state_d = TES_ST_IDLE;
          step_d = '0;
        end else if (step_adv) begin
          step_d = step_q + 5'h1;
        end
      end
      default: begin
        state_d = TES_ST_IDLE;
        step_d = '0;
      end
    endcase
  end

  // Output stage setting, one cycle behind the state
  always_comb begin
    drive_d = '0;
    drive_d.busy = in_edge;
    drive_d.rising = edge_rising;
    drive_d.step = step_q;
    drive_d.shaped = in_edge;
    case (state_q)
      TES_ST_FALL: drive_d.amplitude = tes_ramp(res_sel, n_states - step_q - 5'h1, n_states);
      TES_ST_RISE: drive_d.amplitude = tes_ramp(res_sel, step_q + 5'h1, n_states);
      TES_ST_LOW: drive_d.amplitude = res_sel;
      default: drive_d.amplitude = TES_FULL_CARRIER;
    endcase
    if (in_edge) begin
      drive_d.lut_mode = cur_style.lut;
      drive_d.supply_adapt = cur_style.adapt;
      drive_d.supply_correct = cur_style.correct;
      drive_d.ramp_segments = cur_style.segments;
      if (cur_style.lut) begin
        drive_d.lut_sel = cur_field[1:0];
      end else begin
        drive_d.time_const = cur_field;
      end
    end
  end

  // Register read mux and unmapped-address answer
  always_comb begin
    apb_rsp_d = '0;
    apb_rsp_d.pready = setup_phase;
    if (apb_req_i.paddr == tes_byte_addr(TES_IDX_RES_106K)) begin
      apb_rsp_d.prdata[7:0] = res_106k_q;
    end else if (apb_req_i.paddr == tes_byte_addr(TES_IDX_KIND_106K)) begin
      apb_rsp_d.prdata[7:0] = kind_106k_q;
    end else if (apb_req_i.paddr == tes_byte_addr(TES_IDX_STYLE_106K)) begin
      apb_rsp_d.prdata[7:0] = style_q;
    end else if (apb_req_i.paddr == tes_byte_addr(TES_IDX_LENGTH_106K)) begin
      apb_rsp_d.prdata[7:0] = length_q;
    end else if (apb_req_i.paddr == tes_byte_addr(TES_IDX_RES_212K)) begin
      apb_rsp_d.prdata[7:0] = res_212k_q;
    end else if (apb_req_i.paddr == tes_byte_addr(TES_IDX_KIND_212K)) begin
      apb_rsp_d.prdata[7:0] = kind_212k_q;
    end else if (apb_req_i.paddr == tes_byte_addr(TES_IDX_CTRL)) begin
      apb_rsp_d.prdata[1:0] = ctrl_q;
    end else if (apb_req_i.paddr == tes_byte_addr(TES_IDX_STATUS)) begin
      apb_rsp_d.prdata[10:0] = {in_edge, hold_q, step_q, state_q};
    end else begin
      apb_rsp_d.pslverr = setup_phase;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      apb_rsp_o <= '0;
    end else begin
      apb_rsp_o <= apb_rsp_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      res_106k_q <= TES_RST_RES;
      kind_106k_q <= TES_RST_KIND;
      style_q <= TES_RST_STYLE;
      length_q <= TES_RST_LENGTH;
      res_212k_q <= TES_RST_RES;
      kind_212k_q <= TES_RST_KIND;
      ctrl_q <= TES_RST_CTRL;
    end else begin
      if (wr_res_106k) res_106k_q <= wr_byte;
      if (wr_kind_106k) kind_106k_q <= wr_byte;
      if (wr_style) style_q <= wr_byte & TES_STYLE_MASK;
      if (wr_length) length_q <= wr_byte & TES_LENGTH_MASK;
      if (wr_res_212k) res_212k_q <= wr_byte;
      if (wr_kind_212k) kind_212k_q <= wr_byte;
      if (wr_ctrl) ctrl_q <= wr_byte[1:0] & TES_CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= TES_ST_IDLE;
      step_q <= '0;
      hold_q <= 1'b0;
      tx_drive_o <= '0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      hold_q <= hold_d;
      tx_drive_o <= drive_d;
    end
  end

  // Checks
  sequence fall_done_s;
    (state_q == TES_ST_FALL) && step_adv && last_state;
  endsequence

  apb_ready_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    setup_phase |=> apb_rsp_o.pready)
    else $error("no ready after setup");
  reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    style_q[7] == 1'b0 && style_q[3] == 1'b0 && length_q[6:5] == 2'h0)
    else $error("reserved bits set");
  single_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    in_edge && carrier_tick_i && !double_len && !last_state |=> step_q == $past(step_q) + 5'h1)
    else $error("state held over one carrier cycle");
  double_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    in_edge && carrier_tick_i && double_len && !hold_q |=> step_q == $past(step_q) && hold_q)
    else $error("state left after one carrier cycle");
  fall_count_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    fall_done_s |=> state_q == TES_ST_LOW ##1 tx_drive_o.amplitude == $past(res_sel))
    else $error("falling edge did not end at count");
  low_level_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_LOW |=> tx_drive_o.amplitude == $past(res_sel))
    else $error("modulated level differs from residual");
  lut_select_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_FALL && fall_style.lut |=> tx_drive_o.lut_mode &&
    tx_drive_o.lut_sel == $past(style_q[5:4]))
    else $error("wrong falling lookup table");
  rise_tc_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_RISE && rise_style.valid && !rise_style.lut |=>
    tx_drive_o.time_const == $past(style_q[2:0]) && tx_drive_o.rising)
    else $error("wrong rising time constant");
  fast_rate_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_FALL && rate_212k && kind_212k_q[7:4] == 4'h3 |=>
    tx_drive_o.ramp_segments == 2'h3)
    else $error("fast rate falling style not taken");
  reserved_skip_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_IDLE && shaper_en && mod_req_i && !fall_style.valid |=>
    state_q == TES_ST_LOW)
    else $error("reserved code shaped");

  // Style decode per edge and rate
  fall_tc_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_FALL && fall_style.valid && !fall_style.lut |=> !tx_drive_o.lut_mode &&
    tx_drive_o.time_const == $past(style_q[6:4]) && !tx_drive_o.rising)
    else $error("wrong falling time constant");
  rise_lut_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_RISE && rise_style.lut |=> tx_drive_o.lut_mode &&
    tx_drive_o.lut_sel == $past(style_q[1:0]) && tx_drive_o.rising)
    else $error("wrong rising lookup table");
  rise_fast_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_RISE && rate_212k && kind_212k_q[3:0] == 4'h2 |=>
    tx_drive_o.ramp_segments == 2'h2)
    else $error("fast rate rising style not taken");
  one_ramp_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_FALL && fall_code == 4'h1 |=>
    tx_drive_o.ramp_segments == 2'h1 && !tx_drive_o.lut_mode)
    else $error("single ramp not decoded");
  table_plain_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_FALL && fall_code == 4'h4 |=>
    tx_drive_o.lut_mode && !tx_drive_o.supply_adapt && !tx_drive_o.supply_correct)
    else $error("plain table edge adapted");
  supply_fix_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_FALL && fall_code == 4'h5 |=>
    tx_drive_o.lut_mode && tx_drive_o.supply_adapt && tx_drive_o.supply_correct)
    else $error("corrected table edge not adapted");
  supply_raw_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_RISE && rise_code == 4'h6 |=>
    tx_drive_o.lut_mode && tx_drive_o.supply_adapt && !tx_drive_o.supply_correct)
    else $error("uncorrected table edge wrong");

  // Step timing and levels
  sequence rise_done_s;
    (state_q == TES_ST_RISE) && step_adv && last_state;
  endsequence

  rise_count_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rise_done_s |=> state_q == TES_ST_IDLE ##1 tx_drive_o.amplitude == TES_FULL_CARRIER)
    else $error("rising edge did not end at count");
  scale_rise_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_RISE && carrier_tick_i && double_len && !hold_q |=>
    state_q == TES_ST_RISE && step_q == $past(step_q))
    else $error("rising state not doubled");
  res_fast_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_LOW && rate_212k |=> tx_drive_o.amplitude == $past(res_212k_q))
    else $error("fast rate residual not taken");
  idle_full_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    state_q == TES_ST_IDLE |=> tx_drive_o.amplitude == TES_FULL_CARRIER)
    else $error("idle carrier not full");

  // Bus answer shape
  ready_pulse_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    apb_rsp_o.pslverr |-> apb_rsp_o.pready)
    else $error("error without ready");

endmodule : tes_edge_shaper

// [src/tes_pkg.sv]
// Register map, field layout, states and bus, style and drive types of the tx edge shaper
package tes_pkg;

  localparam int unsigned TES_ADDR_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [5:0] TES_IDX_RES_106K = 6'h14;
  localparam logic [5:0] TES_IDX_KIND_106K = 6'h15;
  localparam logic [5:0] TES_IDX_STYLE_106K = 6'h16;
  localparam logic [5:0] TES_IDX_LENGTH_106K = 6'h17;
  localparam logic [5:0] TES_IDX_RES_212K = 6'h18;
  localparam logic [5:0] TES_IDX_KIND_212K = 6'h19;
  localparam logic [5:0] TES_IDX_CTRL = 6'h20;
  localparam logic [5:0] TES_IDX_STATUS = 6'h21;

  // Writable bit masks; reserved bits are dropped and read as zero
  localparam logic [7:0] TES_STYLE_MASK = 8'h77;
  localparam logic [7:0] TES_LENGTH_MASK = 8'h9f;
  localparam logic [1:0] TES_CTRL_MASK = 2'h3;

  // Field positions
  localparam int unsigned TES_LEN_SCALE_BIT = 7;
  localparam int unsigned TES_CTRL_RATE_BIT = 0;
  localparam int unsigned TES_CTRL_EN_BIT = 1;

  // Values after reset
  localparam logic [7:0] TES_RST_RES = 8'h00;
  localparam logic [7:0] TES_RST_KIND = 8'h00;
  localparam logic [7:0] TES_RST_STYLE = 8'h00;
  localparam logic [7:0] TES_RST_LENGTH = 8'h00;
  localparam logic [1:0] TES_RST_CTRL = 2'h0;

  localparam logic [7:0] TES_FULL_CARRIER = 8'hff;

  typedef enum logic [3:0] {
    TES_ST_IDLE = 4'h1,
    TES_ST_FALL = 4'h2,
    TES_ST_LOW = 4'h4,
    TES_ST_RISE = 4'h8
  } tes_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [TES_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } tes_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tes_apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic lut;
    logic [1:0] segments;
    logic adapt;
    logic correct;
  } tes_style_t;

  typedef struct packed {
    logic [7:0] amplitude;
    logic shaped;
    logic lut_mode;
    logic [1:0] lut_sel;
    logic [2:0] time_const;
    logic [1:0] ramp_segments;
    logic supply_adapt;
    logic supply_correct;
    logic [4:0] step;
    logic rising;
    logic busy;
  } tes_tx_drive_t;

endpackage : tes_pkg

// [verification/tes_out_stage.sv]
// Output stage model: makes one carrier pulse every period_i clocks
module tes_out_stage (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic srst_i, // Synchronous reset
  input wire logic [1:0] period_i, // Clocks per carrier cycle, 1 or 2
  output logic carrier_tick_o // One pulse per carrier cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  assign cnt_d = (cnt_q >= period_i - 2'h1) ? 2'h0 : cnt_q + 2'h1;
  assign carrier_tick_o = !srst_i && cnt_q == 2'h0;
  always_ff @(posedge ref_clk_i) begin
    cnt_q <= srst_i ? 2'h0 : cnt_d;
  end
endmodule : tes_out_stage

// [verification/testbench.sv]
// Self-checking bench of the tx edge shaper
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tes_pkg::*;
  localparam logic [5:0] MAP_IDX [7] = '{TES_IDX_RES_106K, TES_IDX_KIND_106K,
    TES_IDX_STYLE_106K, TES_IDX_LENGTH_106K, TES_IDX_RES_212K, TES_IDX_KIND_212K, TES_IDX_CTRL};
  logic ref_clk_i;
  logic srst_i;
  logic mod_req_i;
  logic carrier_tick_i;
  logic [1:0] period;
  tes_apb_req_t req;
  tes_apb_rsp_t rsp;
  tes_tx_drive_t drv;
  int n_mismatch;
  int n_compared;
  int seed;
  int fall_cnt;
  int rise_cnt;
  int n;
  int m;
  int p;
  int res;
  int stp;
  logic [3:0] fc;
  logic [3:0] rc;
  logic [2:0] ffs;
  logic [2:0] frs;

  tes_edge_shaper dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .apb_req_i(req),
    .apb_rsp_o(rsp), .carrier_tick_i(carrier_tick_i), .mod_req_i(mod_req_i), .tx_drive_o(drv));
  tes_out_stage stage_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .period_i(period),
    .carrier_tick_o(carrier_tick_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     input logic [31:0] exp, input logic exp_err);
    int t;
    @(posedge ref_clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: {24'h0, wd}};
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    t = 0;
    do begin
      @(posedge ref_clk_i);
      t++;
    end while (rsp.pready !== 1'b1 && t < 20);
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t bus timeout", $time);
      end_sim;
    end
    if (!wr) check(rsp.prdata, exp, "read data");
    check({31'h0, rsp.pslverr}, {31'h0, exp_err}, "slave error");
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // Waits for an edge to end at the given level
  task automatic settle(input logic [7:0] amp);
    int t;
    t = 0;
    do begin
      @(negedge ref_clk_i);
      t++;
    end while (!(drv.amplitude === amp && drv.shaped === 1'b0 && drv.busy === 1'b0) && t < 400);
    if (t >= 400) begin
      n_mismatch++;
      $display("FAIL %0t edge timeout", $time);
      end_sim;
    end
  endtask : settle

  // First state may wait up to one carrier period for its first tick
  task automatic check_cnt(input int cnt, input logic [3:0] c);
    int e;
    e = (c >= 1 && c <= 6) ? n * m * p : 0;
    check({31'h0, cnt <= e && cnt + p > e}, 32'h1, "edge length");
    check(stp, (e == 0) ? -1 : n - 1, "last step");
  endtask : check_cnt

  function automatic logic [9:0] fields(input logic [3:0] c, input logic [2:0] f);
    logic lut;
    lut = c >= 4 && c <= 6;
    return {lut, lut ? f[1:0] : 2'h0, lut ? 3'h0 : f, c <= 3 ? c[1:0] : 2'h0,
            c == 5 || c == 6, c == 5};
  endfunction : fields

  always @(negedge ref_clk_i) begin
    if (drv.shaped === 1'b1) begin
      if (drv.rising === 1'b1) rise_cnt++;
      else fall_cnt++;
      check({30'h0, drv.busy, drv.step == stp || drv.step == stp + 1}, 32'h3, "busy step");
      stp = drv.step;
      check({22'h0, drv.lut_mode, drv.lut_sel, drv.time_const, drv.ramp_segments,
             drv.supply_adapt, drv.supply_correct},
            {22'h0, fields(drv.rising ? rc : fc, drv.rising ? frs : ffs)}, "style");
      check({24'h0, drv.amplitude}, res + (255 - res) * (drv.rising ? drv.step + 1 :
            n - drv.step - 1) / n, "amplitude");
    end
  end

  initial begin
    seed = 53704;
    n_mismatch = 0;
    n_compared = 0;
    {fall_cnt, rise_cnt, res, fc, rc, ffs, frs} = '0;
    n = 1;
    srst_i = 1'b1;
    mod_req_i = 1'b0;
    period = 2'h1;
    req = '0;
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    for (int j = 0; j < 7; j++) apb(1'b0, MAP_IDX[j], 8'h0, 32'h0, 1'b0);
    apb(1'b0, TES_IDX_STATUS, 8'h0, 32'h1, 1'b0);
    apb(1'b0, 6'h30, 8'h0, 32'h0, 1'b1);
    apb(1'b1, 6'h30, 8'hff, 32'h0, 1'b1);
    apb(1'b1, TES_IDX_STYLE_106K, 8'hff, 32'h0, 1'b0);
    apb(1'b0, TES_IDX_STYLE_106K, 8'h0, 32'h77, 1'b0);
    apb(1'b1, TES_IDX_LENGTH_106K, 8'hff, 32'h0, 1'b0);
    apb(1'b0, TES_IDX_LENGTH_106K, 8'h0, 32'h9f, 1'b0);
    $display("register test done");
    for (int i = 0; i < 9; i++) begin
      fc = i[3:0];
      rc = 4'(8 - i);
      ffs = 3'($random(seed));
      frs = 3'($random(seed));
      res = $random(seed) & 8'h7e;
      n = (i == 7) ? 31 : 1 + ($random(seed) & 7);
      m = i[0] ? 2 : 1;
      p = i[1] ? 2 : 1;
      period <= 2'(p);
      apb(1'b1, i < 2 ? TES_IDX_KIND_106K : TES_IDX_KIND_212K, {fc, rc}, 0, 1'b0);
      apb(1'b1, i < 2 ? TES_IDX_KIND_212K : TES_IDX_KIND_106K, {rc, fc}, 0, 1'b0);
      apb(1'b1, i < 2 ? TES_IDX_RES_106K : TES_IDX_RES_212K, 8'(res), 0, 1'b0);
      apb(1'b1, i < 2 ? TES_IDX_RES_212K : TES_IDX_RES_106K, 8'(res | 8'h80), 0, 1'b0);
      apb(1'b1, TES_IDX_STYLE_106K, {1'b0, ffs, 1'b0, frs}, 0, 1'b0);
      apb(1'b1, TES_IDX_LENGTH_106K, {m == 2, 2'h0, 5'(n)}, 0, 1'b0);
      apb(1'b1, TES_IDX_CTRL, {6'h0, 1'b1, i >= 2}, 0, 1'b0);
      fall_cnt = 0;
      rise_cnt = 0;
      @(posedge ref_clk_i);
      stp = -1;
      mod_req_i <= 1'b1;
      settle(8'(res));
      check_cnt(fall_cnt, fc);
      @(posedge ref_clk_i);
      stp = -1;
      mod_req_i <= 1'b0;
      settle(8'hff);
      check_cnt(rise_cnt, rc);
      $display("edge case %0d done", i);
    end
    end_sim;
  end
endmodule : testbench
